// [hdl/pcm_pkg.sv]
package pcm_pkg;
	// Clock period of the drive clock in nanoseconds.
	localparam int CLK_PERIOD_NS = 5;
	// One quarter millisecond is the time base of the filter and settle timers.
	localparam int QTR_MS_NS = 250000;
	// Cycles per quarter millisecond, rounded down.
	localparam int QTR_MS_CYC = QTR_MS_NS / CLK_PERIOD_NS;
	// Quarter-millisecond steps in one settle-time step of 1 ms.
	localparam int QTR_PER_MS = 4;
	// Command counts as stopped after this long without an accepted pulse.
	localparam int CMD_IDLE_NS = 1000;
	// Least time, so rounded up.
	localparam int CMD_IDLE_CYC = (CMD_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Cycles after reset release at which the synchronised straps are caught.
	localparam int STRAP_WAIT = 3;
	// Number of general purpose output pins that the two flags can be routed to.
	localparam int NUM_OUT = 4;

	// Register byte addresses on the bus.
	localparam logic [7:0] ADR_DONE_WIDTH = 8'h00;
	localparam logic [7:0] ADR_SETTLE = 8'h04;
	localparam logic [7:0] ADR_NEAR_WIDTH = 8'h08;
	localparam logic [7:0] ADR_ACCEL_FILT = 8'h0c;
	localparam logic [7:0] ADR_AVG_FILT = 8'h10;
	localparam logic [7:0] ADR_DONE_ROUTE = 8'h14;
	localparam logic [7:0] ADR_NEAR_ROUTE = 8'h18;
	localparam logic [7:0] ADR_STATUS = 8'h1c;
	localparam logic [7:0] ADR_DEVIATION = 8'h20;
	localparam logic [7:0] ADR_IRQ_STS = 8'h24;
	localparam logic [7:0] ADR_IRQ_CLR = 8'h28;
	localparam logic [7:0] ADR_IRQ_EN = 8'h2c;

	// Values after reset.
	localparam logic [31:0] RST_DONE_WIDTH = 32'h0000_0007;
	localparam logic [31:0] RST_SETTLE = 32'h0000_0000;
	localparam logic [31:0] RST_NEAR_WIDTH = 32'h4000_0000;
	localparam logic [31:0] RST_FILT = 32'h0000_0000;
	localparam logic [31:0] RST_DONE_ROUTE = 32'h0000_0000;
	localparam logic [31:0] RST_NEAR_ROUTE = 32'h0000_0001;
	// Writable bits of the window widths (values up to two to the thirty-first minus one).
	localparam logic [31:0] WIDTH_MASK = 32'h7fff_ffff;

	// Control mode codes in which the pulse inhibit input is honoured.
	localparam logic [3:0] MODE_POS = 4'h1;
	localparam logic [3:0] MODE_IVEL_POS = 4'h4;
	localparam logic [3:0] MODE_POS_VEL = 4'h7;
	localparam logic [3:0] MODE_POS_TRQ = 4'h8;
	localparam logic [3:0] MODE_IPOS_POS = 4'hb;

	// Interrupt bit positions.
	localparam int IRQ_DONE_RISE = 0;
	localparam int IRQ_DONE_FALL = 1;
	localparam int IRQ_NEAR_RISE = 2;
	localparam int IRQ_NEAR_FALL = 3;

	// Qualification of the completion flag.
	typedef enum logic [1:0] {PCM_TS_DEV = 2'h0, PCM_TS_FILT = 2'h1, PCM_TS_RAW = 2'h2} pcm_tsel_t;
	// Completion state, Gray coded along out, settle, done.
	typedef enum logic [1:0] {PCM_OUT = 2'b00, PCM_SETTLE = 2'b01, PCM_DONE = 2'b11} pcm_state_t;
endpackage

// [hdl/pcm_top.sv]
`timescale 1ns/100ps
// Contract
// - Done asserts in window after settle, qualified.
// - Done stays low while deviation exceeds window.
// - Done window 0 to 2^30, reset 7, immediate. Code accepts up to 2^31-1.
// - Timing select: deviation, filtered stop, raw stop.
// - Filtered stop waits accel plus average filter time.
// - Settle time 0 to 1000 ms, reset 0. Code accepts up to 1023 ms.
// - Near asserts while deviation below near window.
// - Near drops while deviation exceeds near window.
// - Near window 1 to 2^30, reset 2^30. Code accepts up to 2^31-1.
// - Inhibit discards command pulses until released.
// - Inhibit honoured only in position modes.
// - Mode select, position modes, applied at power-on.
// - Done has default pin, routable to any.
// - Near routable to any output pin.
// - Deviation is command count minus feedback count.
module pcm_top #(
	parameter int unsigned QTR_CYC = pcm_pkg::QTR_MS_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cmd_pulse_i,
	input wire logic cmd_dir_i,
	input wire logic fb_pulse_i,
	input wire logic fb_dir_i,
	input wire logic pulse_inhibit_i,
	input wire logic [1:0] timing_strap_i,
	input wire logic [3:0] mode_strap_i,
	output logic positioning_done_o,
	output logic near_target_o,
	output logic [pcm_pkg::NUM_OUT-1:0] out_pin_o,
	output logic irq_o
);
	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	logic [10:0] sync1_reg; // First synchroniser stage, read only by the second.
	logic [10:0] sync2_reg; // Second stage, safe for logic.
	logic [1:0] pls_prev_reg; // Previous synced pulse levels for edge detection.
	logic [1:0] strap_cnt_reg; // Counts cycles after reset release.
	pcm_pkg::pcm_tsel_t tsel_reg; // Timing select caught at power-on.
	logic [3:0] mode_reg; // Control mode caught at power-on.
	logic [31:0] done_width_reg, settle_reg, near_width_reg; // Software settings.
	logic [31:0] accel_reg, avg_reg, done_route_reg, near_route_reg;
	logic [3:0] irq_sts_reg, irq_en_reg; // Sticky events and their enables.
	logic signed [31:0] dev_reg; // Position deviation counter.
	logic [7:0] idle_reg; // Cycles since the last accepted command pulse.
	logic [15:0] filt_pre_reg, set_pre_reg; // Quarter-millisecond prescalers.
	logic [15:0] filt_qtr_reg; // Quarter milliseconds since the raw command stopped.
	logic [11:0] set_qtr_reg; // Quarter milliseconds spent settling.
	pcm_pkg::pcm_state_t state_reg, state_next; // Completion state.
	logic [31:0] rd_data; // Combinational read data.
	logic [3:0] irq_sts_next, irq_ev;
	logic acc, wr, cmd_take, fb_edge, pos_mode, inhibit_on, raw_stop, filt_stop;
	logic in_done, in_near, qual, settle_over, filt_tick, set_tick;
	logic [31:0] mag;
	logic [15:0] filt_total;

	// Pins come from outside the clock domain: two flops before any logic.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			pls_prev_reg <= '0;
		end
		else
		begin
			sync1_reg <= {mode_strap_i, timing_strap_i, pulse_inhibit_i, fb_dir_i, fb_pulse_i,
				cmd_dir_i, cmd_pulse_i};
			sync2_reg <= sync1_reg;
			pls_prev_reg <= {sync2_reg[2], sync2_reg[0]};
		end
	end

	// The straps are setup values: caught once after release, then frozen until the next reset.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			strap_cnt_reg <= '0;
			tsel_reg <= pcm_pkg::PCM_TS_DEV;
			mode_reg <= pcm_pkg::MODE_POS;
		end
		else if (strap_cnt_reg != 2'(pcm_pkg::STRAP_WAIT))
		begin
			strap_cnt_reg <= strap_cnt_reg + 2'd1;
			if (strap_cnt_reg == 2'(pcm_pkg::STRAP_WAIT - 1))
			begin
				tsel_reg <= pcm_pkg::pcm_tsel_t'(sync2_reg[6:5]);
				mode_reg <= sync2_reg[10:7];
			end
		end
	end

	// Inhibit applies only in the modes that include position control.
	always_comb
	begin
		pos_mode = (mode_reg == pcm_pkg::MODE_POS) || (mode_reg == pcm_pkg::MODE_IVEL_POS)
			|| (mode_reg == pcm_pkg::MODE_POS_VEL) || (mode_reg == pcm_pkg::MODE_POS_TRQ)
			|| (mode_reg == pcm_pkg::MODE_IPOS_POS);
		inhibit_on = sync2_reg[4] && pos_mode;
		cmd_take = sync2_reg[0] && !pls_prev_reg[0] && !inhibit_on;
		fb_edge = sync2_reg[2] && !pls_prev_reg[1];
	end

	// Command pulses add one to the deviation and feedback pulses subtract one, each negated when its direction pin is high.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			dev_reg <= '0;
		end
		else
		begin
			dev_reg <= dev_reg + (cmd_take ? {{31{sync2_reg[1]}}, 1'b1} : 32'sh0000_0000)
				- (fb_edge ? {{31{sync2_reg[3]}}, 1'b1} : 32'sh0000_0000);
		end
	end

	// Window tests on the deviation magnitude; equal to the width counts as outside.
	always_comb
	begin
		mag = dev_reg[31] ? 32'(-dev_reg) : 32'(dev_reg);
		in_done = mag < done_width_reg;
		in_near = mag < near_width_reg;
		filt_total = accel_reg[15:0] + avg_reg[15:0];
		raw_stop = idle_reg == 8'(pcm_pkg::CMD_IDLE_CYC);
		filt_stop = raw_stop && (filt_qtr_reg >= filt_total);
		filt_tick = filt_pre_reg == 16'(QTR_CYC - 1);
		set_tick = set_pre_reg == 16'(QTR_CYC - 1);
	end

	// Idle timer; it starts saturated so that a fresh drive reads as stopped.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			idle_reg <= 8'(pcm_pkg::CMD_IDLE_CYC);
		end
		else if (cmd_take)
		begin
			idle_reg <= '0;
		end
		else if (!raw_stop)
		begin
			idle_reg <= idle_reg + 8'd1;
		end
	end

	// Models the smoothing delay: counts filter time after the raw command stopped.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || !raw_stop)
		begin
			filt_pre_reg <= '0;
			filt_qtr_reg <= '0;
		end
		else if (!filt_stop)
		begin
			filt_pre_reg <= filt_tick ? 16'h0000 : filt_pre_reg + 16'd1;
			if (filt_tick)
			begin
				filt_qtr_reg <= filt_qtr_reg + 16'd1;
			end
		end
	end

	// Qualified window test and the completion state machine.
	always_comb
	begin
		unique case (tsel_reg)
			pcm_pkg::PCM_TS_FILT: qual = in_done && filt_stop;
			pcm_pkg::PCM_TS_RAW: qual = in_done && raw_stop;
			pcm_pkg::PCM_TS_DEV: qual = in_done;
			default: qual = in_done; // Code 3 is illegal and falls back to the plain test.
		endcase
		settle_over = set_qtr_reg >= {settle_reg[9:0], 2'b00};
		state_next = state_reg;
		unique case (state_reg)
			pcm_pkg::PCM_OUT:
			begin
				if (qual)
				begin
					state_next = (settle_reg == 32'h0000_0000) ? pcm_pkg::PCM_DONE
						: pcm_pkg::PCM_SETTLE;
				end
			end
			pcm_pkg::PCM_SETTLE:
			begin
				if (!qual)
				begin
					state_next = pcm_pkg::PCM_OUT;
				end
				else if (settle_over)
				begin
					state_next = pcm_pkg::PCM_DONE;
				end
			end
			pcm_pkg::PCM_DONE:
			begin
				if (!qual)
				begin
					state_next = pcm_pkg::PCM_OUT;
				end
			end
		endcase
	end

	// Settle timer runs only while settling, so each leave of the window restarts it.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || state_reg != pcm_pkg::PCM_SETTLE)
		begin
			set_pre_reg <= '0;
			set_qtr_reg <= '0;
		end
		else
		begin
			set_pre_reg <= set_tick ? 16'h0000 : set_pre_reg + 16'd1;
			if (set_tick && !settle_over)
			begin
				set_qtr_reg <= set_qtr_reg + 12'd1;
			end
		end
	end

	// State and flag outputs, all straight from flops.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= pcm_pkg::PCM_OUT;
			positioning_done_o <= 1'b0;
			near_target_o <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			positioning_done_o <= state_next == pcm_pkg::PCM_DONE;
			near_target_o <= in_near;
		end
	end

	// Each output pin carries whichever flag is routed to it; both may share a pin.
	genvar g;
	generate
		for (g = 0; g < pcm_pkg::NUM_OUT; g++)
		begin : g_pin
			always_ff @(posedge clk_i)
			begin
				if (!rstn_i)
				begin
					out_pin_o[g] <= 1'b0;
				end
				else
				begin
					out_pin_o[g] <= ((done_route_reg[1:0] == 2'(g)) && state_next == pcm_pkg::PCM_DONE)
						|| ((near_route_reg[1:0] == 2'(g)) && in_near);
				end
			end
		end
	endgenerate

	// A request is taken in the cycle in which strobe is high and ack is low; ack comes one cycle later.
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = acc && wb_we_i;

	// Software settings; all take effect on the cycle after the write.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			done_width_reg <= pcm_pkg::RST_DONE_WIDTH;
			settle_reg <= pcm_pkg::RST_SETTLE;
			near_width_reg <= pcm_pkg::RST_NEAR_WIDTH;
			accel_reg <= pcm_pkg::RST_FILT;
			avg_reg <= pcm_pkg::RST_FILT;
			done_route_reg <= pcm_pkg::RST_DONE_ROUTE;
			near_route_reg <= pcm_pkg::RST_NEAR_ROUTE;
			irq_en_reg <= '0;
		end
		else if (wr)
		begin
			unique case (wb_adr_i)
				pcm_pkg::ADR_DONE_WIDTH: done_width_reg <= merge(done_width_reg, wb_dat_i, wb_sel_i)
					& pcm_pkg::WIDTH_MASK;
				pcm_pkg::ADR_SETTLE: settle_reg <= merge(settle_reg, wb_dat_i, wb_sel_i)
					& 32'h0000_03ff;
				pcm_pkg::ADR_NEAR_WIDTH: near_width_reg <= merge(near_width_reg, wb_dat_i, wb_sel_i)
					& pcm_pkg::WIDTH_MASK | 32'h0000_0000;
				pcm_pkg::ADR_ACCEL_FILT: accel_reg <= merge(accel_reg, wb_dat_i, wb_sel_i) & 32'h0000_7fff;
				pcm_pkg::ADR_AVG_FILT: avg_reg <= merge(avg_reg, wb_dat_i, wb_sel_i) & 32'h0000_03ff;
				pcm_pkg::ADR_DONE_ROUTE: done_route_reg <= merge(done_route_reg, wb_dat_i, wb_sel_i)
					& 32'h0000_0003;
				pcm_pkg::ADR_NEAR_ROUTE: near_route_reg <= merge(near_route_reg, wb_dat_i, wb_sel_i)
					& 32'h0000_0003;
				pcm_pkg::ADR_IRQ_EN: irq_en_reg <= 4'(merge({28'h000_0000, irq_en_reg}, wb_dat_i,
					wb_sel_i));
				default: ; // Read-only, write-only clear and unmapped addresses store nothing here.
			endcase
		end
		else if (near_width_reg == 32'h0000_0000)
		begin
			near_width_reg <= 32'h0000_0001; // A zero write is raised to the least width.
		end
	end

	// Flag edges are the interrupt events; a set in the clear cycle wins.
	always_comb
	begin
		irq_ev = '0;
		irq_ev[pcm_pkg::IRQ_DONE_RISE] = (state_next == pcm_pkg::PCM_DONE) && !positioning_done_o;
		irq_ev[pcm_pkg::IRQ_DONE_FALL] = (state_next != pcm_pkg::PCM_DONE) && positioning_done_o;
		irq_ev[pcm_pkg::IRQ_NEAR_RISE] = in_near && !near_target_o;
		irq_ev[pcm_pkg::IRQ_NEAR_FALL] = !in_near && near_target_o;
		irq_sts_next = irq_sts_reg;
		if (wr && wb_adr_i == pcm_pkg::ADR_IRQ_CLR && wb_sel_i[0])
		begin
			irq_sts_next = irq_sts_reg & ~wb_dat_i[3:0];
		end
		irq_sts_next = irq_sts_next | irq_ev;
	end

	// Sticky status and the level interrupt.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			irq_sts_reg <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_sts_reg <= irq_sts_next;
			irq_o <= |(irq_sts_next & irq_en_reg);
		end
	end

	// Read multiplexer; unmapped and write-only addresses read as zero.
	always_comb
	begin
		unique case (wb_adr_i)
			pcm_pkg::ADR_DONE_WIDTH: rd_data = done_width_reg;
			pcm_pkg::ADR_SETTLE: rd_data = settle_reg;
			pcm_pkg::ADR_NEAR_WIDTH: rd_data = near_width_reg;
			pcm_pkg::ADR_ACCEL_FILT: rd_data = accel_reg;
			pcm_pkg::ADR_AVG_FILT: rd_data = avg_reg;
			pcm_pkg::ADR_DONE_ROUTE: rd_data = done_route_reg;
			pcm_pkg::ADR_NEAR_ROUTE: rd_data = near_route_reg;
			pcm_pkg::ADR_STATUS: rd_data = {19'h0_0000, mode_reg, tsel_reg, inhibit_on, raw_stop,
				filt_stop, in_near, in_done, state_reg};
			pcm_pkg::ADR_DEVIATION: rd_data = dev_reg;
			pcm_pkg::ADR_IRQ_STS: rd_data = {28'h000_0000, irq_sts_reg};
			pcm_pkg::ADR_IRQ_EN: rd_data = {28'h000_0000, irq_en_reg};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// Bus answer: one-cycle ack, dropped in the following cycle.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= acc;
			wb_dat_o <= (acc && !wb_we_i) ? rd_data : 32'h0000_0000;
		end
	end
endmodule

// [verification/pcm_pulse_src.sv]
`timescale 1ns/100ps
// Pulse and direction source in the place of the motion controller or the encoder.
module pcm_pulse_src (
	input wire logic clk_i,
	output logic pulse_o,
	output logic dir_o
);
	// The pins idle low so that no stray edge is counted before the first call.
	initial
	begin
		pulse_o = 1'b0;
		dir_o = 1'b0;
	end
	// Direction settles three cycles ahead of the first edge, since it is caught with the edge.
	// Each level lasts three cycles, one more than the synchroniser needs to see it.
	task automatic send(input int cnt, input logic dir);
		dir_o <= dir;
		repeat (3) @(posedge clk_i);
		repeat (cnt)
		begin
			pulse_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			pulse_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask
endmodule

// [verification/pcm_top_props.sv]
`timescale 1ns/100ps
// Watches the bus handshake and the completion flag at the pins of the top module.
module pcm_top_props #(
	parameter int unsigned QTR_CYC = pcm_pkg::QTR_MS_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic cmd_pulse_i,
	input wire logic pulse_inhibit_i,
	input wire logic [1:0] timing_strap_i,
	input wire logic positioning_done_o,
	input wire logic near_target_o,
	input wire logic [pcm_pkg::NUM_OUT-1:0] out_pin_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// Cycles since the last uninhibited command edge at the pin; it saturates.
	// It runs ahead of the synchronised count, so the gap check errs on the lenient side.
	logic [15:0] idle_cnt_reg;
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			idle_cnt_reg <= 16'hffff;
		else if ($rose(cmd_pulse_i) && !pulse_inhibit_i)
			idle_cnt_reg <= 16'h0000;
		else if (idle_cnt_reg != 16'hffff)
			idle_cnt_reg <= idle_cnt_reg + 16'h0001;
	end
	// A request that is not yet answered.
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// A command edge that counts while a stop qualification is selected.
	sequence s_cmd_go;
		$rose(cmd_pulse_i) && !pulse_inhibit_i && timing_strap_i inside {2'h1, 2'h2};
	endsequence
	AST_ACK_ONE: assert property (s_req |=> wb_ack_o)
		else $error("request not answered in one cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("acknowledge without a request");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside acknowledge");
	AST_DAT_WR: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000)
		else $error("read data on a write");
	AST_RST_QUIET: assert property ($rose(rstn_i) |-> !positioning_done_o && !near_target_o
		&& out_pin_o == '0 && !irq_o && !wb_ack_o)
		else $error("outputs not low after reset");
	AST_STOP_DROP: assert property (s_cmd_go |-> ##[1:8] !positioning_done_o)
		else $error("completion held while command moves");
	AST_STOP_GAP: assert property ($rose(positioning_done_o)
		&& timing_strap_i inside {2'h1, 2'h2} |-> idle_cnt_reg >= pcm_pkg::CMD_IDLE_CYC)
		else $error("completion before command stopped");
endmodule
bind pcm_top pcm_top_props #(.QTR_CYC(QTR_CYC)) i_pcm_top_props (.clk_i(clk_i), .rstn_i(rstn_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .cmd_pulse_i(cmd_pulse_i), .pulse_inhibit_i(pulse_inhibit_i),
	.timing_strap_i(timing_strap_i), .positioning_done_o(positioning_done_o),
	.near_target_o(near_target_o), .out_pin_o(out_pin_o), .irq_o(irq_o));

// [verification/position_completion_monitor_tb.sv]
`timescale 1ns/100ps
module position_completion_monitor_tb;
	// A short quarter millisecond keeps the settle and filter runs brief.
	localparam int QTR = 8;
	localparam int IDLE = pcm_pkg::CMD_IDLE_CYC;
	logic clk_i, rstn_i, wb_cyc, wb_stb, wb_we, wb_ack, inhibit;
	logic cmd_pulse, cmd_dir, fb_pulse, fb_dir, done, near, irq;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel, mode, pins;
	logic [1:0] tsel;
	logic [31:0] wb_wdat, wb_rdat, rd;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	// The first five modes are position modes.
	logic [3:0] modes [7] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'hb, 4'h2, 4'h0};
	pcm_top #(.QTR_CYC(QTR)) i_pcm_top (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .cmd_pulse_i(cmd_pulse),
		.cmd_dir_i(cmd_dir), .fb_pulse_i(fb_pulse), .fb_dir_i(fb_dir), .pulse_inhibit_i(inhibit),
		.timing_strap_i(tsel), .mode_strap_i(mode), .positioning_done_o(done),
		.near_target_o(near), .out_pin_o(pins), .irq_o(irq));
	pcm_pulse_src i_cmd_src (.clk_i(clk_i), .pulse_o(cmd_pulse), .dir_o(cmd_dir));
	pcm_pulse_src i_fb_src (.clk_i(clk_i), .pulse_o(fb_pulse), .dir_o(fb_dir));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic give_up();
		mismatches++;
		complete_run();
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One classic cycle; it holds everything until ack is sampled high.
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int k;
		k = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hf;
		wb_wdat <= wd;
		@(posedge clk_i);
		while (wb_ack !== 1'b1 && k < 50)
		begin
			k++;
			@(posedge clk_i);
		end
		if (k == 50)
			give_up();
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0000_0000);
		check(rd, exp);
	endtask
	// Straps are set under reset and held, since they are caught only after release.
	task automatic reset_dut(input logic [3:0] m, input logic [1:0] t);
		rstn_i <= 1'b0;
		mode <= m;
		tsel <= t;
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic wait_done(output int k);
		k = 0;
		while (done !== 1'b1 && k < 1000)
		begin
			k++;
			@(posedge clk_i);
		end
		if (k == 1000)
			give_up();
	endtask
	initial
	begin
		{rstn_i, wb_cyc, wb_stb, wb_we, inhibit} = 5'h00;
		{wb_adr, wb_sel, wb_wdat, mode, tsel} = '0;
		reset_dut(4'h1, 2'h0);
		rd_chk(pcm_pkg::ADR_DONE_WIDTH, 32'h0000_0007);
		rd_chk(pcm_pkg::ADR_SETTLE, 32'h0000_0000);
		rd_chk(pcm_pkg::ADR_NEAR_WIDTH, 32'h4000_0000);
		rd_chk(8'h3c, 32'h0000_0000);
		check(pins, 4'h3);
		$display("reset test ended");
		i_cmd_src.send(7, 1'b0);
		check(done, 1'b0);
		check(near, 1'b1);
		rd_chk(pcm_pkg::ADR_DEVIATION, 32'h0000_0007);
		bus(1'b1, pcm_pkg::ADR_NEAR_WIDTH, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		check(near, 1'b0);
		bus(1'b1, pcm_pkg::ADR_DONE_WIDTH, 32'h0000_0008);
		repeat (2) @(posedge clk_i);
		check(done, 1'b1);
		bus(1'b1, pcm_pkg::ADR_NEAR_WIDTH, 32'h0000_0000);
		rd_chk(pcm_pkg::ADR_NEAR_WIDTH, 32'h0000_0001);
		bus(1'b1, pcm_pkg::ADR_NEAR_WIDTH, 32'h4000_0000);
		i_cmd_src.send(10, 1'b1);
		rd_chk(pcm_pkg::ADR_DEVIATION, 32'hffff_fffd);
		check(done, 1'b1);
		i_fb_src.send(3, 1'b1);
		$display("window test ended");
		// Enter the window, leave it briefly, and re-enter: the settle count must start over.
		bus(1'b1, pcm_pkg::ADR_SETTLE, 32'h0000_0001);
		i_cmd_src.send(8, 1'b0);
		check(done, 1'b0);
		i_fb_src.send(1, 1'b0);
		i_cmd_src.send(1, 1'b0);
		i_fb_src.send(1, 1'b0);
		wait_done(n);
		check(n >= 4 * QTR - 4 && n <= 4 * QTR + 8, 1'b1);
		bus(1'b1, pcm_pkg::ADR_SETTLE, 32'h0000_0000);
		$display("settle test ended");
		bus(1'b1, pcm_pkg::ADR_IRQ_EN, 32'h0000_0000);
		bus(1'b1, pcm_pkg::ADR_IRQ_CLR, 32'h0000_000f);
		i_cmd_src.send(1, 1'b0);
		i_fb_src.send(1, 1'b0);
		check(irq, 1'b0);
		rd_chk(pcm_pkg::ADR_IRQ_STS, 32'h0000_0003);
		bus(1'b1, pcm_pkg::ADR_IRQ_EN, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b1);
		bus(1'b1, pcm_pkg::ADR_IRQ_CLR, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check(irq, 1'b0);
		rd_chk(pcm_pkg::ADR_IRQ_STS, 32'h0000_0002);
		bus(1'b1, pcm_pkg::ADR_NEAR_ROUTE, 32'h0000_0003);
		bus(1'b1, pcm_pkg::ADR_DONE_ROUTE, 32'h0000_0002);
		repeat (2) @(posedge clk_i);
		check(pins, 4'hc);
		$display("interrupt and route test ended");
		// Raw stop, then filtered stop that adds three quarter-millisecond ticks.
		for (int t = 2; t > 0; t--)
		begin
			reset_dut(4'h1, t[1:0]);
			bus(1'b1, pcm_pkg::ADR_ACCEL_FILT, 32'h0000_0002);
			bus(1'b1, pcm_pkg::ADR_AVG_FILT, 32'h0000_0001);
			i_cmd_src.send(1, 1'b0);
			i_fb_src.send(1, 1'b0);
			wait_done(n);
			n = n - (t == 1 ? 3 * QTR : 0);
			check(n >= IDLE - 20 && n <= IDLE + 2, 1'b1);
		end
		$display("timing select test ended");
		// Two pulses under inhibit are lost only in the position modes.
		foreach (modes[i])
		begin
			reset_dut(modes[i], 2'h0);
			inhibit <= 1'b1;
			i_cmd_src.send(2, 1'b0);
			inhibit <= 1'b0;
			repeat (3) @(posedge clk_i);
			i_cmd_src.send(1, 1'b0);
			rd_chk(pcm_pkg::ADR_DEVIATION, i < 5 ? 32'h0000_0001 : 32'h0000_0003);
		end
		$display("inhibit test ended");
		complete_run();
	end
endmodule
